// ==== rtl/can_int_encoder.sv ====
// The implementer's own choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module can_int_encoder
   import can_int_pkg::*;
#(
   parameter int ADDR_W = 5
)
(
   input wire logic clock,
   input wire logic reset,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [DATA_W-1:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [DATA_W-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [1:0] rx_msg_event,
   input wire logic [2:0] tx_msg_event,
   input wire logic wake_event,
   input wire logic invalid_msg_event,
   input wire logic rx_overrun_event,
   input wire logic rx_warn_event,
   input wire logic tx_warn_event,
   input wire logic rx_passive_event,
   input wire logic tx_passive_event,
   input wire logic bus_off_event,
   output logic irq
);

   if (ADDR_W < ADDR_W_MIN) begin : g_addr_check
      $error("can_int_encoder: ADDR_W too small for the register map");
   end

   function automatic reg_sel_t decode(input logic [ADDR_W-1:0] addr);
      reg_sel_t sel;
      sel = SEL_NONE;
      if (addr[ADDR_W-1:0] == ADDR_W'(FLAG_OFS)) begin
         sel = SEL_FLAG;
      end else if (addr == ADDR_W'(ENABLE_OFS)) begin
         sel = SEL_ENABLE;
      end else if (addr == ADDR_W'(STATUS_OFS)) begin
         sel = SEL_STATUS;
      end else if (addr == ADDR_W'(COMM_OFS)) begin
         sel = SEL_COMM;
      end else if (addr == ADDR_W'(MODE_OFS)) begin
         sel = SEL_MODE;
      end
      return sel;
   endfunction : decode

   logic awready_reg;
   logic wready_reg;
   logic bvalid_reg;
   logic [1:0] bresp_reg;
   logic arready_reg;
   logic rvalid_reg;
   logic [1:0] rresp_reg;
   logic [DATA_W-1:0] rdata_reg;
   logic [ADDR_W-1:0] waddr_reg;
   logic [REG_W-1:0] wdata_reg;
   logic wlane_reg;

   logic [REG_W-1:0] flag_reg;
   logic [REG_W-1:0] enable_reg;
   logic [COMM_W-1:0] comm_status_reg;
   mode_t mode_reg;
   code_t code_reg;
   logic irq_reg;

   logic do_write;
   reg_sel_t wsel;
   reg_sel_t rsel;
   logic lane_write;
   logic [REG_W-1:0] flag_set;
   logic [COMM_W-1:0] comm_event;
   logic [REG_W-1:0] pending;
   code_t code_next;
   logic [DATA_W-1:0] rdata_next;
   logic shared_mode;

   // Address and data are each held once taken; the write happens when
   // both are in and no response is outstanding
   assign do_write = !awready_reg && !wready_reg && !bvalid_reg;
   assign wsel = decode(waddr_reg);
   assign rsel = decode(s_axi_araddr);
   assign lane_write = do_write && wlane_reg;
   assign shared_mode = (mode_reg == MODE_ENHANCED) ||
                        (mode_reg == MODE_FIFO);

   always_ff @(posedge clock) begin
      if (reset) begin
         awready_reg <= 1'b1;
         waddr_reg <= '0;
      end else if (s_axi_awvalid && awready_reg) begin
         awready_reg <= 1'b0;
         waddr_reg <= s_axi_awaddr;
      end else if (bvalid_reg && s_axi_bready) begin
         awready_reg <= 1'b1;
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         wready_reg <= 1'b1;
         wdata_reg <= '0;
         wlane_reg <= 1'b0;
      end else if (s_axi_wvalid && wready_reg) begin
         wready_reg <= 1'b0;
         wdata_reg <= s_axi_wdata[REG_W-1:0];
         wlane_reg <= s_axi_wstrb[0];
      end else if (bvalid_reg && s_axi_bready) begin
         wready_reg <= 1'b1;
      end
   end

   // Unmapped addresses still complete, with an error response, so a
   // stray access never hangs the bus
   always_ff @(posedge clock) begin
      if (reset) begin
         bvalid_reg <= 1'b0;
         bresp_reg <= RESP_OKAY;
      end else if (do_write) begin
         bvalid_reg <= 1'b1;
         bresp_reg <= (wsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_bready) begin
         bvalid_reg <= 1'b0;
      end
   end

   // Registers are one byte wide, so only lane 0 of the data matters
   always_comb begin
      rdata_next = '0;
      case (rsel)
         SEL_FLAG: rdata_next[REG_W-1:0] = flag_reg;
         SEL_ENABLE: rdata_next[REG_W-1:0] = enable_reg;
         SEL_STATUS: begin
            rdata_next[CODE_LSB +: CODE_W] = code_reg;
            rdata_next[MODE_LSB +: 2] = mode_reg;
         end
         SEL_COMM: rdata_next[COMM_W-1:0] = comm_status_reg;
         SEL_MODE: rdata_next[1:0] = mode_reg;
         default: rdata_next = '0;
      endcase
   end

   // Read data is caught at the address handshake, so a flag that moves
   // later cannot tear a word already on its way back
   always_ff @(posedge clock) begin
      if (reset) begin
         arready_reg <= 1'b1;
         rvalid_reg <= 1'b0;
         rresp_reg <= RESP_OKAY;
         rdata_reg <= '0;
      end else if (s_axi_arvalid && arready_reg) begin
         arready_reg <= 1'b0;
         rvalid_reg <= 1'b1;
         rresp_reg <= (rsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
         rdata_reg <= rdata_next;
      end else if (rvalid_reg && s_axi_rready) begin
         arready_reg <= 1'b1;
         rvalid_reg <= 1'b0;
      end
   end

   // Error sources, receive and transmit sides mixed, in one vector
   always_comb begin
      comm_event = '0;
      comm_event[OVR_BIT] = rx_overrun_event;
      comm_event[RX_WARN_BIT] = rx_warn_event;
      comm_event[RX_PASS_BIT] = rx_passive_event;
      comm_event[TX_WARN_BIT] = tx_warn_event;
      comm_event[TX_PASS_BIT] = tx_passive_event;
      comm_event[BUS_OFF_BIT] = bus_off_event;
   end

   always_comb begin
      flag_set = '0;
      if (shared_mode) begin
         flag_set[RX_ALL_BIT] = |rx_msg_event;
         flag_set[TX_ALL_BIT] = |tx_msg_event;
      end else begin
         flag_set[RX0_BIT] = rx_msg_event[0];
         flag_set[RX1_BIT] = rx_msg_event[1];
         flag_set[TX0_BIT] = tx_msg_event[0];
         flag_set[TX1_BIT] = tx_msg_event[1];
         flag_set[TX2_BIT] = tx_msg_event[2];
      end
      flag_set[ERR_BIT] = |comm_event;
      flag_set[WAKE_BIT] = wake_event;
      flag_set[INVMSG_BIT] = invalid_msg_event;
   end

   // A hardware set in the same cycle as a software clear wins
   always_ff @(posedge clock) begin
      if (reset) begin
         flag_reg <= FLAG_RST;
      end else if (lane_write && wsel == SEL_FLAG) begin
         flag_reg <= wdata_reg | flag_set;
      end else begin
         flag_reg <= flag_reg | flag_set;
      end
   end

   // Enables are plain storage; a disabled source still sets its flag
   always_ff @(posedge clock) begin
      if (reset) begin
         enable_reg <= ENABLE_RST;
      end else if (lane_write && wsel == SEL_ENABLE) begin
         enable_reg <= wdata_reg;
      end
   end

   // Each error cause is a sticky bit; software clears by writing 0
   for (genvar i = 0; i < COMM_W; i++) begin : g_comm
      always_ff @(posedge clock) begin
         if (reset) begin
            comm_status_reg[i] <= COMM_RST[i];
         end else if (comm_event[i]) begin
            comm_status_reg[i] <= 1'b1;
         end else if (lane_write && wsel == SEL_COMM) begin
            comm_status_reg[i] <= wdata_reg[i];
         end
      end
   end

   // Reserved mode value 3 is refused; the mode stays as it was
   always_ff @(posedge clock) begin
      if (reset) begin
         mode_reg <= MODE_RST;
      end else if (lane_write && wsel == SEL_MODE &&
                   wdata_reg[1:0] != 2'h3) begin
         mode_reg <= wdata_reg[1:0];
      end
   end

   assign pending = flag_reg & enable_reg;

   can_int_prio u_prio (
      .pending(pending),
      .mode(mode_reg),
      .code(code_next)
   );

   // Code follows the pending set every cycle, so a cleared source gives
   // way to the next one; writes to the status word never reach it
   always_ff @(posedge clock) begin
      if (reset) begin
         code_reg <= CODE_NONE;
      end else if (shared_mode) begin
         code_reg <= code_next;
      end else begin
         code_reg <= {2'b00, code_next[LEGACY_CODE_W-1:0]};
      end
   end

   // Registered so the request never glitches toward the core; it lags
   // the pending set by one clock
   always_ff @(posedge clock) begin
      if (reset) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= |pending;
      end
   end

   assign s_axi_awready = awready_reg;
   assign s_axi_wready = wready_reg;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;
   assign s_axi_arready = arready_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rresp = rresp_reg;
   assign s_axi_rdata = rdata_reg;
   assign irq = irq_reg;

endmodule : can_int_encoder

// ==== rtl/can_int_pkg.sv ====
package can_int_pkg;

   localparam int DATA_W = 32;
   localparam int REG_W = 8;
   localparam int ADDR_W_MIN = 5;

   // Byte addresses of the register words
   localparam logic [4:0] FLAG_OFS = 5'h00;
   localparam logic [4:0] ENABLE_OFS = 5'h04;
   localparam logic [4:0] STATUS_OFS = 5'h08;
   localparam logic [4:0] COMM_OFS = 5'h0c;
   localparam logic [4:0] MODE_OFS = 5'h10;

   // Flag and enable bit positions
   localparam int RX0_BIT = 0;
   localparam int RX1_BIT = 1;
   localparam int TX0_BIT = 2;
   localparam int TX1_BIT = 3;
   localparam int TX2_BIT = 4;
   localparam int ERR_BIT = 5;
   localparam int WAKE_BIT = 6;
   localparam int INVMSG_BIT = 7;
   // Shared buffer flags in enhanced and FIFO modes
   localparam int RX_ALL_BIT = RX0_BIT;
   localparam int TX_ALL_BIT = TX0_BIT;

   // Communication status bit positions
   localparam int COMM_W = 6;
   localparam int OVR_BIT = 0;
   localparam int RX_WARN_BIT = 1;
   localparam int TX_WARN_BIT = 2;
   localparam int RX_PASS_BIT = 3;
   localparam int TX_PASS_BIT = 4;
   localparam int BUS_OFF_BIT = 5;

   // Controller status field positions
   localparam int CODE_LSB = 0;
   localparam int CODE_W = 5;
   localparam int LEGACY_CODE_W = 3;
   localparam int MODE_LSB = 6;

   // Reset values
   localparam logic [REG_W-1:0] FLAG_RST = 8'h00;
   localparam logic [REG_W-1:0] ENABLE_RST = 8'h00;
   localparam logic [COMM_W-1:0] COMM_RST = 6'h00;

   typedef logic [1:0] mode_t;
   localparam mode_t MODE_LEGACY = 2'h0;
   localparam mode_t MODE_ENHANCED = 2'h1;
   localparam mode_t MODE_FIFO = 2'h2;
   localparam mode_t MODE_RST = MODE_LEGACY;

   typedef logic [CODE_W-1:0] code_t;
   localparam code_t CODE_NONE = 5'h00;
   localparam code_t LG_ERR = 5'h01;
   localparam code_t LG_TX2 = 5'h02;
   localparam code_t LG_TX1 = 5'h03;
   localparam code_t LG_TX0 = 5'h04;
   localparam code_t LG_RX1 = 5'h05;
   localparam code_t LG_RX0 = 5'h06;
   localparam code_t LG_WAKE = 5'h07;
   localparam code_t EX_ERR = 5'h01;
   localparam code_t EX_TX = 5'h02;
   localparam code_t EX_RX = 5'h03;
   localparam code_t EX_WAKE = 5'h04;
   localparam code_t EX_INVMSG = 5'h05;
   localparam code_t EX_FIFO_RX = 5'h10;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum {SEL_FLAG, SEL_ENABLE, SEL_STATUS, SEL_COMM, SEL_MODE,
                 SEL_NONE} reg_sel_t;

endpackage : can_int_pkg

// ==== rtl/can_int_prio.sv ====
`timescale 1ns/1ps
module can_int_prio
   import can_int_pkg::*;
(
   input wire logic [REG_W-1:0] pending,
   input wire mode_t mode,
   output code_t code
);

   // Earlier branches win; the most urgent source gets the lowest code, except in FIFO mode, where receive gets EX_FIFO_RX
   always_comb begin
      code = CODE_NONE;
      if (mode == MODE_ENHANCED || mode == MODE_FIFO) begin
         if (pending[ERR_BIT]) begin
            code = EX_ERR;
         end else if (pending[TX_ALL_BIT]) begin
            code = EX_TX;
         end else if (pending[RX_ALL_BIT]) begin
            // FIFO firmware finds the buffer through its pointer bits
            code = (mode == MODE_FIFO) ? EX_FIFO_RX : EX_RX;
         end else if (pending[WAKE_BIT]) begin
            code = EX_WAKE;
         end else if (pending[INVMSG_BIT]) begin
            code = EX_INVMSG;
         end
      end else begin
         // Legacy field has no code left for the invalid-message source
         if (pending[ERR_BIT]) begin
            code = LG_ERR;
         end else if (pending[TX2_BIT]) begin
            code = LG_TX2;
         end else if (pending[TX1_BIT]) begin
            code = LG_TX1;
         end else if (pending[TX0_BIT]) begin
            code = LG_TX0;
         end else if (pending[RX1_BIT]) begin
            code = LG_RX1;
         end else if (pending[RX0_BIT]) begin
            code = LG_RX0;
         end else if (pending[WAKE_BIT]) begin
            code = LG_WAKE;
         end
      end
   end

endmodule : can_int_prio

// ==== verification/can_int_encoder_sva.sv ====
`timescale 1ns/1ps
module can_int_encoder_sva
   import can_int_pkg::*;
#(
   parameter int ADDR_W = 5
)
(
   input wire logic clock,
   input wire logic reset,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [DATA_W-1:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic irq
);
   logic [ADDR_W-1:0] ar_q;
   logic st;
   default clocking @(posedge clock); endclocking
   default disable iff (reset);
   // Remembers which word the pending read answer belongs to
   always_ff @(posedge clock) begin
      if (s_axi_arvalid && s_axi_arready) begin
         ar_q <= s_axi_araddr;
      end
   end
   assign st = s_axi_rvalid && ar_q == ADDR_W'(STATUS_OFS);
   property p_legacy;
      st && s_axi_rdata[7:6] == MODE_LEGACY |-> s_axi_rdata[4:3] == 2'h0;
   endproperty
   a_legacy: assert property (p_legacy) else $error("legacy code wide");
   property p_enh;
      st && s_axi_rdata[7:6] == MODE_ENHANCED |-> s_axi_rdata[4] == 1'b0;
   endproperty
   a_enh: assert property (p_enh) else $error("enhanced code bad");
   property p_fifo;
      st && s_axi_rdata[7:6] == MODE_FIFO |-> s_axi_rdata[4:0] != EX_RX;
   endproperty
   a_fifo: assert property (p_fifo) else $error("fifo rx code bad");
   property p_code_irq;
      $rose(s_axi_rvalid) && st && s_axi_rdata[4:0] != CODE_NONE
         |-> $past(irq);
   endproperty
   a_code_irq: assert property (p_code_irq) else $error("code no irq");
   property p_none;
      $rose(s_axi_rvalid) && st && s_axi_rdata[7:6] != MODE_LEGACY &&
         s_axi_rdata[4:0] == CODE_NONE |-> !$past(irq);
   endproperty
   a_none: assert property (p_none) else $error("irq with no code");
   property p_unmap;
      s_axi_arvalid && s_axi_arready && s_axi_araddr > ADDR_W'(MODE_OFS)
         |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == '0;
   endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read");
   property p_upper;
      s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0;
   endproperty
   a_upper: assert property (p_upper) else $error("upper bits set");
   property p_rans;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
   endproperty
   a_rans: assert property (p_rans) else $error("read not answered");
   c_fifo_rx: cover property (st && s_axi_rdata[4:0] == EX_FIFO_RX);
   c_irq: cover property ($rose(irq));
   c_unmap: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
endmodule : can_int_encoder_sva

bind can_int_encoder can_int_encoder_sva #(.ADDR_W(ADDR_W)) u_sva (
   .clock(clock),
   .reset(reset),
   .s_axi_araddr(s_axi_araddr),
   .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata),
   .s_axi_rresp(s_axi_rresp),
   .s_axi_rvalid(s_axi_rvalid),
   .irq(irq)
);

// ==== verification/can_int_encoder_tb.sv ====
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin errors++; \
$display("ERROR %0t got %h exp %h", $time, a, b); end end
module can_int_encoder_tb
   import can_int_pkg::*;
();
   logic clock, reset, awv, wv, bready, arv, rready, lane0;
   logic awr, wrdy, bv, arr, rv, irq;
   logic [4:0] awaddr, araddr;
   logic [31:0] wdata, rdata, d;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, r;
   logic [12:0] ev;
   logic [7:0] e, f;
   logic [15:0] taken;
   int errors, cmp_count, i, m, k;
   localparam logic [4:0] OFS [5] = '{FLAG_OFS, ENABLE_OFS, STATUS_OFS,
      COMM_OFS, MODE_OFS};
   can_int_encoder #(.ADDR_W(5)) u_can_int_encoder (
      .clock(clock), .reset(reset),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awr),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wv),
      .s_axi_wready(wrdy), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arv),
      .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rv), .s_axi_rready(rready),
      .rx_msg_event(ev[1:0]), .tx_msg_event(ev[4:2]), .wake_event(ev[5]),
      .invalid_msg_event(ev[6]), .rx_overrun_event(ev[7]),
      .rx_warn_event(ev[8]), .tx_warn_event(ev[9]),
      .rx_passive_event(ev[10]), .tx_passive_event(ev[11]),
      .bus_off_event(ev[12]), .irq(irq)
   );
   core_irq_model u_core_irq_model (
      .clock(clock), .reset(reset), .irq(irq), .taken(taken)
   );
   always #5 clock = ~clock;
   // Expected status word: mode field over the code of the top source
   function automatic logic [31:0] st_exp(input logic [7:0] p,
                                          input mode_t md);
      code_t c;
      c = CODE_NONE;
      if (md == MODE_LEGACY) begin
         if (p[WAKE_BIT]) c = LG_WAKE;
         if (p[RX0_BIT]) c = LG_RX0;
         if (p[RX1_BIT]) c = LG_RX1;
         if (p[TX0_BIT]) c = LG_TX0;
         if (p[TX1_BIT]) c = LG_TX1;
         if (p[TX2_BIT]) c = LG_TX2;
      end else begin
         if (p[INVMSG_BIT]) c = EX_INVMSG;
         if (p[WAKE_BIT]) c = EX_WAKE;
         if (p[RX_ALL_BIT]) c = md == MODE_FIFO ? EX_FIFO_RX : EX_RX;
         if (p[TX_ALL_BIT]) c = EX_TX;
      end
      if (p[ERR_BIT]) c = md == MODE_LEGACY ? LG_ERR : EX_ERR;
      return (32'(md) << MODE_LSB) | 32'(c);
   endfunction : st_exp
   function automatic logic [7:0] ef(input int n, input mode_t md);
      logic lg;
      lg = md == MODE_LEGACY;
      if (n < 2) return 8'h1 << (lg ? RX0_BIT + n : RX_ALL_BIT);
      if (n < 5) return 8'h1 << (lg ? TX0_BIT + n - 2 : TX_ALL_BIT);
      if (n == 5) return 8'h1 << WAKE_BIT;
      if (n == 6) return 8'h1 << INVMSG_BIT;
      return 8'h1 << ERR_BIT;
   endfunction : ef
   task automatic wr(input logic [4:0] a, input logic [31:0] dv,
                     output logic [1:0] rs);
      logic ad, wd;
      ad = 1'b0;
      wd = 1'b0;
      @(posedge clock);
      awaddr <= a;
      wdata <= dv;
      wstrb <= {3'($urandom), lane0};
      awv <= 1'b1;
      wv <= 1'b1;
      bready <= 1'b1;
      while (!(ad && wd)) begin
         @(posedge clock);
         if (awr && !ad) begin
            ad = 1'b1;
            awv <= 1'b0;
         end
         if (wrdy && !wd) begin
            wd = 1'b1;
            wv <= 1'b0;
         end
      end
      do @(posedge clock); while (!bv);
      rs = bresp;
      bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [4:0] a, output logic [31:0] dv,
                     output logic [1:0] rs);
      @(posedge clock);
      araddr <= a;
      arv <= 1'b1;
      rready <= 1'b1;
      do @(posedge clock); while (!arr);
      arv <= 1'b0;
      do @(posedge clock); while (!rv);
      dv = rdata;
      rs = rresp;
      rready <= 1'b0;
   endtask : rd
   task end_of_test;
      $display("compares %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : end_of_test
   // Whole run needs about a thousand cycles; this leaves ample margin
   initial begin
      repeat (30000) @(posedge clock);
      errors++;
      $display("ERROR %0t watchdog expired", $time);
      end_of_test;
   end
   initial begin
      {clock, awv, wv, bready, arv, rready, awaddr, araddr} = '0;
      {wdata, wstrb, ev, errors, cmp_count} = '0;
      reset = 1'b1;
      lane0 = 1'b1;
      void'($urandom(16));
      repeat (12) @(posedge clock);
      reset <= 1'b0;
      foreach (OFS[n]) begin
         rd(OFS[n], d, r);
         `CHK({r, d}, {RESP_OKAY, 32'h0})
      end
      $display("test reset done");
      for (m = 0; m < 2; m++) begin
         wr(MODE_OFS, 32'(m), r);
         wr(ENABLE_OFS, 32'hff, r);
         for (i = 0; i < 13; i++) begin
            wr(FLAG_OFS, 32'h0, r);
            wr(COMM_OFS, 32'h0, r);
            @(posedge clock) ev <= 13'h1 << i;
            @(posedge clock) ev <= 13'h0;
            rd(FLAG_OFS, d, r);
            `CHK(d[7:0], ef(i, mode_t'(m)))
            rd(COMM_OFS, d, r);
            `CHK(d[5:0], i > 6 ? 6'h1 << (i - 7) : 6'h0)
         end
      end
      $display("test events done");
      for (m = 0; m < 3; m++) begin
         wr(MODE_OFS, 32'(m), r);
         for (k = 0; k < 12; k++) begin
            e = k == 0 ? 8'h00 : 8'($urandom);
            f = k < 2 ? 8'hff : 8'($urandom);
            // Shared modes never set the per-buffer bits 1, 3 and 4
            if (m != 0) f = f & 8'he5;
            wr(ENABLE_OFS, {24'($urandom), e}, r);
            wr(FLAG_OFS, {24'($urandom), f}, r);
            rd(STATUS_OFS, d, r);
            `CHK(d, st_exp(f & e, mode_t'(m)))
            `CHK(irq, |(f & e))
         end
      end
      $display("test priority done");
      wr(STATUS_OFS, $urandom, r);
      `CHK(r, RESP_OKAY)
      rd(STATUS_OFS, d, r);
      `CHK(d, st_exp(f & e, MODE_FIFO))
      // Reserved mode value must leave the mode as it was
      wr(MODE_OFS, 32'h3, r);
      rd(MODE_OFS, d, r);
      `CHK({r, d}, {RESP_OKAY, 32'(MODE_FIFO)})
      // A write without byte lane 0 must not touch the enables
      lane0 = 1'b0;
      wr(ENABLE_OFS, 32'h0, r);
      lane0 = 1'b1;
      rd(ENABLE_OFS, d, r);
      `CHK(d, 32'(e))
      // First word past the map, then the last word of the address space
      wr(5'h14, 32'hff, r);
      `CHK(r, RESP_SLVERR)
      rd(5'h1c, d, r);
      `CHK({r, d}, {RESP_SLVERR, 32'h0})
      `CHK(taken != 16'h0, 1'b1)
      $display("test access done");
      end_of_test;
   end
endmodule : can_int_encoder_tb

// ==== verification/core_irq_model.sv ====
`timescale 1ns/1ps
module core_irq_model (
   input wire logic clock,
   input wire logic reset,
   input wire logic irq,
   output logic [15:0] taken
);
   logic irq_reg;
   // The core reacts to the rising edge of the request, once per assertion
   always_ff @(posedge clock) begin
      if (reset) begin
         irq_reg <= 1'b0;
         taken <= 16'h0;
      end else begin
         irq_reg <= irq;
         if (irq && !irq_reg) begin
            taken <= taken + 16'h1;
         end
      end
   end
endmodule : core_irq_model
